/* File: fws_cfg.svh */
// Register map, field positions, reset values and timing of the write sequencer
// Notes on behaviour
// - Pause request stops a running word, double-word program or sector erase.
// - Entering pause releases the bank to read mode and drops its busy bit.
// - In paused program only its own resume is accepted; others refused.
// - In paused erase, erase resume or a non-pausable program is accepted.
// - Start bit launches every operation; hardware clears it at end or pause.
// - Start while the write error flag is high is refused.
// - Writing zero to the start bit does nothing.
// - Bank 0 sector bits sit at 9:0 of the low sector register.
// - Bank 1 sector bits sit at 1:0 of the high sector register.
// - Sector bits show erase status; cleared after an error-free operation.
// - Bank status bits follow erase; cleared after an error-free erase.
// - Set status means error if error flag set, else paused if pause set.
// - Address and data words are held steady during a program.
// - Start sets bank busy; busy drops at end or pause, returns on resume.
// - Three select bits choose the operation and clear when it ends.
// - Error flag rises on failure or bad setup; software clears it.
`ifndef FWS_CFG_SVH
`define FWS_CFG_SVH

`define FWS_OFS_STAT_LO   24'h0E0000
`define FWS_OFS_CTL_HI    24'h0E0002
`define FWS_OFS_SEC_LO    24'h0E0004
`define FWS_OFS_SEC_HI    24'h0E0006
`define FWS_OFS_DATA_BASE 24'h0E0008
`define FWS_OFS_ADDR_HI   24'h0E0012
`define FWS_OFS_ERR       24'h0E0014

`define FWS_BIT_START     15
`define FWS_BIT_PAUSE     14
`define FWS_BIT_WORD      13
`define FWS_BIT_DWORD     12
`define FWS_BIT_ERASE     11
`define FWS_BIT_BUSY0     1
`define FWS_BIT_BUSY1     2
`define FWS_BIT_LOCK      4
`define FWS_BIT_BSTAT0    14
`define FWS_BIT_BSTAT1    15
`define FWS_B0_SEC_W      10
`define FWS_B1_SEC_W      2

`define FWS_BIT_ERR       0
`define FWS_BIT_ERER      1
`define FWS_BIT_PGER      2
`define FWS_BIT_SEQER     6
`define FWS_BIT_RESER     7

`define FWS_IDX_ADDR_LO   4
`define FWS_IDX_ADDR_HI   5
`define FWS_BIT_ADD2      2
`define FWS_BIT_BANKSEL   2

`define FWS_RST_CTL       16'h0000
`define FWS_RST_SEC       16'h0000
`define FWS_RST_DATA      16'hFFFF
`define FWS_RST_ADDR      16'h0000
`define FWS_RST_ERR       16'h0000

`define FWS_CLK_NS        10
`define FWS_TICK_NS       1000
`define FWS_TICK_CYCLES   (`FWS_TICK_NS / `FWS_CLK_NS)
`define FWS_PROG_TICKS    20
`define FWS_ERASE_TICKS   1000

`endif

/* File: fws_pkg.sv */
// Types shared by the write sequencer files
`default_nettype none
package fws_pkg;
   typedef enum logic [1:0] {
      FWS_IDLE = 2'b00,
      FWS_RUN  = 2'b01,
      FWS_HELD = 2'b10,
      FWS_NEST = 2'b11
   } fws_state_type;

   typedef logic [2:0] fws_sel_type;
   localparam fws_sel_type FWS_SEL_WORD  = 3'h4;
   localparam fws_sel_type FWS_SEL_DWORD = 3'h2;
   localparam fws_sel_type FWS_SEL_ERASE = 3'h1;
endpackage
`default_nettype wire

/* File: fws_op_timer.sv */
// Pausable countdown that models the duration of one array operation
`timescale 1ns/100ps
`default_nettype none
module fws_op_timer #(
   parameter int CNT_W = 16
) (
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   input  wire logic             tick_i,
   input  wire logic             load_i,
   input  wire logic [CNT_W-1:0] len_i,
   input  wire logic             run_i,
   input  wire logic             abort_i,
   output logic                  done_o
);
   logic [CNT_W-1:0] cnt_reg;
   logic             active_reg;

   // Done is combinational so a pause in the same cycle cannot hide it
   assign done_o = active_reg && run_i && tick_i
                   && (cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1});

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_reg    <= '0;
         active_reg <= 1'b0;
      end else if (load_i) begin
         cnt_reg    <= len_i;
         active_reg <= 1'b1;
      end else if (abort_i || done_o) begin
         active_reg <= 1'b0;
      end else if (active_reg && run_i && tick_i) begin
         cnt_reg    <= cnt_reg - 1'b1;
      end
   end
endmodule // fws_op_timer
`default_nettype wire

/* File: fws_word_store.sv */
// Small word store for the program address and data registers
`timescale 1ns/100ps
`default_nettype none
module fws_word_store #(
   parameter int                      DATA_W = 16,
   parameter int                      DEPTH  = 6,
   parameter int                      IDX_W  = 3,
   parameter logic [DEPTH*DATA_W-1:0] RST    = '0
) (
   input  wire logic                    clk_i,
   input  wire logic                    nrst_i,
   input  wire logic                    we_i,
   input  wire logic [IDX_W-1:0]        widx_i,
   input  wire logic [DATA_W-1:0]       wdata_i,
   input  wire logic                    re_i,
   input  wire logic [IDX_W-1:0]        ridx_i,
   output logic      [DATA_W-1:0]       rdata_o,
   output logic      [DEPTH*DATA_W-1:0] words_o
);
   genvar g;
   generate
      for (g = 0; g < DEPTH; g = g + 1) begin : g_word
         logic [DATA_W-1:0] word_reg;
         always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i)
               word_reg <= RST[g*DATA_W +: DATA_W];
            else if (we_i && (widx_i == IDX_W'(g)))
               word_reg <= wdata_i;
         end
         assign words_o[g*DATA_W +: DATA_W] = word_reg;
      end
   endgenerate

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i)
         rdata_o <= '0;
      else if (re_i)
         rdata_o <= words_o[ridx_i*DATA_W +: DATA_W];
   end
endmodule // fws_word_store
`default_nettype wire

/* File: fws_ctrl.sv */
// Write start, pause and sector status control of the flash write sequencer
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "fws_cfg.svh"
module fws_ctrl #(
   parameter int ADDR_W      = 24,
   parameter int CNT_W       = 16,
   parameter int PROG_TICKS  = `FWS_PROG_TICKS,
   parameter int ERASE_TICKS = `FWS_ERASE_TICKS
) (
   input  wire logic              clk_i,
   input  wire logic              nrst_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [15:0]       wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [15:0]       rdata_o,
   input  wire logic              array_fail_i,
   output logic      [1:0]        bank_busy_o,
   output logic                   lock_o,
   output logic                   array_run_o,
   output logic      [2:0]        array_op_o,
   output logic                   array_bank_o
);
   localparam logic [15:0] TICK_LAST = 16'(`FWS_TICK_CYCLES - 1);
   localparam logic [CNT_W-1:0] PROG_LEN  = CNT_W'(PROG_TICKS);
   localparam logic [CNT_W-1:0] ERASE_LEN = CNT_W'(ERASE_TICKS);
   localparam logic [15:0]      RST_SEC   = `FWS_RST_SEC;

   fws_pkg::fws_state_type state_reg, state_next;
   fws_pkg::fws_sel_type   sel_reg, held_sel_reg;
   logic                   start_reg, pause_reg;
   logic [1:0]             busy_reg, bstat_reg;
   logic [`FWS_B0_SEC_W-1:0] sec0_reg;
   logic [`FWS_B1_SEC_W-1:0] sec1_reg;
   logic                   run_bank_reg, held_bank_reg;
   logic                   err_reg, erer_reg, pger_reg, seqer_reg, reser_reg;
   logic [15:0]            tick_cnt_reg, other_q_reg;
   logic                   from_store_reg;

   // Slow tick for the operation timers
   wire tick = (tick_cnt_reg == TICK_LAST);

   // Address decode
   wire hit_stat  = (addr_i == `FWS_OFS_STAT_LO);
   wire hit_ctl   = (addr_i == `FWS_OFS_CTL_HI);
   wire hit_sec0  = (addr_i == `FWS_OFS_SEC_LO);
   wire hit_sec1  = (addr_i == `FWS_OFS_SEC_HI);
   wire hit_err   = (addr_i == `FWS_OFS_ERR);
   wire hit_store = (addr_i >= `FWS_OFS_DATA_BASE)
                    && (addr_i <= `FWS_OFS_ADDR_HI) && !addr_i[0];
   wire [ADDR_W-1:0] store_off = addr_i - `FWS_OFS_DATA_BASE;
   wire [2:0]        store_idx = store_off[3:1];

   wire st_idle = (state_reg == fws_pkg::FWS_IDLE);
   wire st_run  = (state_reg == fws_pkg::FWS_RUN);
   wire st_held = (state_reg == fws_pkg::FWS_HELD);
   wire st_nest = (state_reg == fws_pkg::FWS_NEST);

   wire [95:0] words;
   wire [15:0] store_q;
   wire [15:0] addr_lo = words[`FWS_IDX_ADDR_LO*16 +: 16];
   wire [15:0] addr_hi = words[`FWS_IDX_ADDR_HI*16 +: 16];

   // Start request decode; a zero written to start is simply not a request
   wire wr_ctl    = wr_i && hit_ctl;
   wire start_req = wr_ctl && wdata_i[`FWS_BIT_START] && !start_reg;
   wire fws_pkg::fws_sel_type req_sel = {wdata_i[`FWS_BIT_WORD],
      wdata_i[`FWS_BIT_DWORD], wdata_i[`FWS_BIT_ERASE]};
   wire req_erase = (req_sel == fws_pkg::FWS_SEL_ERASE);
   wire req_prog  = (req_sel == fws_pkg::FWS_SEL_WORD)
                    || (req_sel == fws_pkg::FWS_SEL_DWORD);
   wire erase_b0  = |sec0_reg;
   wire erase_b1  = |sec1_reg;
   // Erase must name sectors of exactly one bank
   wire setup_bad = !(req_erase || req_prog)
                    || (req_erase && (erase_b0 == erase_b1))
                    || ((req_sel == fws_pkg::FWS_SEL_DWORD)
                        && addr_lo[`FWS_BIT_ADD2]);
   wire req_bank  = req_erase ? erase_b1 : addr_hi[`FWS_BIT_BANKSEL];
   wire held_erase = (held_sel_reg == fws_pkg::FWS_SEL_ERASE);
   wire resume_ok  = (req_sel == held_sel_reg);
   wire nest_try   = held_erase && req_prog;

   // Request outcome; refusal starts nothing and keeps the select bits, though the pause bit still takes the written value
   wire base_ok  = start_req && !err_reg
                   && !wdata_i[`FWS_BIT_PAUSE];
   wire acc_new  = base_ok && st_idle && !setup_bad;
   wire acc_res  = base_ok && st_held && resume_ok;
   wire acc_nest = base_ok && st_held && !resume_ok && nest_try
                   && !setup_bad;
   wire seq_fail = start_req && !err_reg
                   && (wdata_i[`FWS_BIT_PAUSE]
                       || (st_idle && setup_bad)
                       || (st_held && !resume_ok && nest_try && setup_bad));
   wire res_fail = base_ok && st_held && !resume_ok && !nest_try;
   wire start_evt = acc_new || acc_res || acc_nest;
   wire refused   = start_req && !start_evt;

   wire done_a, done_b;
   wire run_erase = (sel_reg == fws_pkg::FWS_SEL_ERASE);
   wire end_a   = st_run && done_a;
   wire end_b   = st_nest && done_b;
   wire end_evt = end_a || end_b;
   wire fail_end = end_evt && array_fail_i;
   // Only the outer operation can pause; a nested program runs to its end
   wire pause_request_bit_evt = st_run && wr_ctl && wdata_i[`FWS_BIT_PAUSE]
                   && !done_a;
   wire op_bank  = acc_res ? held_bank_reg : req_bank;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         fws_pkg::FWS_IDLE: begin
            if (acc_new)
               state_next = fws_pkg::FWS_RUN;
         end
         fws_pkg::FWS_RUN: begin
            if (end_a)
               state_next = fws_pkg::FWS_IDLE;
            else if (pause_request_bit_evt)
               state_next = fws_pkg::FWS_HELD;
         end
         fws_pkg::FWS_HELD: begin
            if (acc_res)
               state_next = fws_pkg::FWS_RUN;
            else if (acc_nest)
               state_next = fws_pkg::FWS_NEST;
            else if (res_fail)
               state_next = fws_pkg::FWS_IDLE;
         end
         fws_pkg::FWS_NEST: begin
            if (end_b)
               state_next = fws_pkg::FWS_HELD;
         end
      endcase
   end

   // Control bits
   wire start_next = start_evt ? 1'b1 :
                     (end_evt || pause_request_bit_evt) ? 1'b0 : start_reg;
   wire sel_we     = wr_ctl && !start_reg && !refused;
   wire fws_pkg::fws_sel_type sel_next = end_evt ? 3'h0 :
                     sel_we ? req_sel : sel_reg;
   wire pause_next = wr_ctl ? wdata_i[`FWS_BIT_PAUSE] : pause_reg;
   wire [1:0] busy_next = start_evt ? (op_bank ? 2'b10 : 2'b01) :
                     (end_evt || pause_request_bit_evt) ? 2'b00 : busy_reg;

   // Sector bits are settings in idle and status once an erase has begun
   wire sec_we0 = wr_i && hit_sec0 && st_idle;
   wire sec_we1 = wr_i && hit_sec1 && st_idle;
   wire sec_clr = end_evt && !array_fail_i;
   wire [`FWS_B0_SEC_W-1:0] sec0_next = sec_clr ? '0 :
      sec_we0 ? wdata_i[`FWS_B0_SEC_W-1:0] : sec0_reg;
   wire [`FWS_B1_SEC_W-1:0] sec1_next = sec_clr ? '0 :
      sec_we1 ? wdata_i[`FWS_B1_SEC_W-1:0] : sec1_reg;
   wire erase_go = (acc_new && req_erase) || (acc_res && held_erase);
   wire [1:0] bstat_next = erase_go ? (bstat_reg | (op_bank ? 2'b10 : 2'b01)) :
      (end_a && run_erase && !array_fail_i) ? 2'b00 : bstat_reg;

   // Error bits: hardware set wins over a software clear in the same cycle
   wire err_clr = wr_i && hit_err && !start_reg;
   wire err_next   = (seq_fail || res_fail || fail_end)
      || (err_reg && !(err_clr && !wdata_i[`FWS_BIT_ERR]));
   wire erer_next  = (end_a && run_erase && array_fail_i)
      || (erer_reg && !(err_clr && !wdata_i[`FWS_BIT_ERER]));
   wire pger_next  = (((end_a && !run_erase) || end_b) && array_fail_i)
      || (pger_reg && !(err_clr && !wdata_i[`FWS_BIT_PGER]));
   wire seqer_next = seq_fail
      || (seqer_reg && !(err_clr && !wdata_i[`FWS_BIT_SEQER]));
   wire reser_next = res_fail
      || (reser_reg && !(err_clr && !wdata_i[`FWS_BIT_RESER]));

   // Address and data stay frozen while a program runs or is paused
   wire store_we = wr_i && hit_store && !start_reg
                   && !(st_held && !held_erase);
   wire store_re = rd_i && hit_store && !start_reg;

   // Read side; locked registers read as zero except the status word
   wire [15:0] stat_word = 16'(({15'h0, start_reg} << `FWS_BIT_LOCK)
      | ({15'h0, busy_reg[0]} << `FWS_BIT_BUSY0)
      | ({15'h0, busy_reg[1]} << `FWS_BIT_BUSY1));
   wire [15:0] ctl_word  = {start_reg, pause_reg, sel_reg, 11'h000};
   wire [15:0] sec0_word = {6'h00, sec0_reg};
   // Status meaning depends on error and pause flags, decoded by software
   wire [15:0] sec1_word = {bstat_reg[1], bstat_reg[0], 12'h000,
                            sec1_reg};
   wire [15:0] err_word  = {8'h00, reser_reg, seqer_reg, 3'h0,
                            pger_reg, erer_reg, err_reg};
   wire [15:0] read_mux  =
      hit_stat                ? stat_word :
      start_reg               ? 16'h0000  :
      hit_ctl                 ? ctl_word  :
      hit_sec0                ? sec0_word :
      hit_sec1                ? sec1_word :
      hit_err                 ? err_word  : 16'h0000;

   assign rdata_o      = from_store_reg ? store_q : other_q_reg;
   assign bank_busy_o  = busy_reg;
   assign lock_o       = start_reg;
   assign array_run_o  = st_run || st_nest;
   assign array_op_o   = (st_run || st_nest) ? sel_reg : 3'h0;
   assign array_bank_o = run_bank_reg;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg      <= fws_pkg::FWS_IDLE;
         start_reg      <= 1'b0;
         pause_reg      <= 1'b0;
         sel_reg        <= 3'h0;
         held_sel_reg   <= 3'h0;
         busy_reg       <= 2'b00;
         bstat_reg      <= 2'b00;
         sec0_reg       <= RST_SEC[`FWS_B0_SEC_W-1:0];
         sec1_reg       <= RST_SEC[`FWS_B1_SEC_W-1:0];
      end else begin
         state_reg      <= state_next;
         start_reg      <= start_next;
         pause_reg      <= pause_next;
         sel_reg        <= sel_next;
         busy_reg       <= busy_next;
         bstat_reg      <= bstat_next;
         sec0_reg       <= sec0_next;
         sec1_reg       <= sec1_next;
         if (pause_request_bit_evt)
            held_sel_reg <= sel_reg;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         run_bank_reg  <= 1'b0;
         held_bank_reg <= 1'b0;
         err_reg       <= 1'b0;
         erer_reg      <= 1'b0;
         pger_reg      <= 1'b0;
         seqer_reg     <= 1'b0;
         reser_reg     <= 1'b0;
      end else begin
         if (start_evt)
            run_bank_reg <= op_bank;
         if (pause_request_bit_evt)
            held_bank_reg <= run_bank_reg;
         err_reg       <= err_next;
         erer_reg      <= erer_next;
         pger_reg      <= pger_next;
         seqer_reg     <= seqer_next;
         reser_reg     <= reser_next;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tick_cnt_reg   <= 16'h0000;
         other_q_reg    <= 16'h0000;
         from_store_reg <= 1'b0;
      end else begin
         tick_cnt_reg   <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
         from_store_reg <= store_re;
         if (rd_i)
            other_q_reg <= read_mux;
      end
   end

   fws_word_store #(
      .DATA_W (16),
      .DEPTH  (6),
      .IDX_W  (3),
      .RST    ({`FWS_RST_ADDR, `FWS_RST_ADDR, `FWS_RST_DATA,
                `FWS_RST_DATA, `FWS_RST_DATA, `FWS_RST_DATA})
   ) u_store (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .we_i    (store_we),
      .widx_i  (store_idx),
      .wdata_i (wdata_i),
      .re_i    (store_re),
      .ridx_i  (store_idx),
      .rdata_o (store_q),
      .words_o (words)
   );

   // Outer operation timer keeps its count across a pause
   fws_op_timer #(.CNT_W (CNT_W)) u_timer_main (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .tick_i  (tick),
      .load_i  (acc_new),
      .len_i   (req_erase ? ERASE_LEN : PROG_LEN),
      .run_i   (st_run),
      .abort_i (res_fail),
      .done_o  (done_a)
   );

   fws_op_timer #(.CNT_W (CNT_W)) u_timer_nest (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .tick_i  (tick),
      .load_i  (acc_nest),
      .len_i   (PROG_LEN),
      .run_i   (st_nest),
      .abort_i (1'b0),
      .done_o  (done_b)
   );
endmodule // fws_ctrl
`default_nettype wire

/* File: fws_ctrl_assertions.sv */
// Port assertions for the flash write sequencer control block
`timescale 1ns/100ps
`default_nettype none
`include "fws_cfg.svh"
module fws_checker #(
   parameter int ADDR_W = 24
) (
   input wire logic              clk_i,
   input wire logic              nrst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [15:0]       wdata_i,
   input wire logic              wr_i,
   input wire logic              rd_i,
   input wire logic [15:0]       rdata_o,
   input wire logic              array_fail_i,
   input wire logic [1:0]        bank_busy_o,
   input wire logic              lock_o,
   input wire logic              array_run_o,
   input wire logic [2:0]        array_op_o,
   input wire logic              array_bank_o
);
   wire logic       ctl_wr   = wr_i && addr_i == `FWS_OFS_CTL_HI;
   wire logic       pause_wr = ctl_wr && wdata_i[`FWS_BIT_PAUSE];
   wire logic       start_wr = ctl_wr && wdata_i[`FWS_BIT_START]
                               && !wdata_i[`FWS_BIT_PAUSE];
   wire logic       is_erase = array_op_o == fws_pkg::FWS_SEL_ERASE;
   wire logic [1:0] own_busy = array_bank_o ? 2'h2 : 2'h1;
   // Marks a paused erase; a program nested in it may ignore pause
   logic            erase_held_reg;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         erase_held_reg <= 1'b0;
      end else if (lock_o && is_erase) begin
         erase_held_reg <= pause_wr;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);

   a_start_cause: assert property (
      $rose(lock_o) |-> $past(start_wr))
      else $error("lock rose without a start write");
   a_run_lock: assert property (
      array_run_o == lock_o)
      else $error("run and lock disagree");
   a_op_onehot: assert property (
      array_run_o |-> $onehot(array_op_o))
      else $error("running without a single select");
   a_idle_op: assert property (
      !array_run_o |-> array_op_o == 3'h0)
      else $error("select left set while idle");
   a_busy_bank: assert property (
      bank_busy_o == (lock_o ? own_busy : 2'h0))
      else $error("busy bits do not match running bank");
   a_pause_clear: assert property (
      lock_o && pause_wr && !(erase_held_reg && !is_erase)
      |=> !lock_o && !array_run_o && bank_busy_o == 2'h0)
      else $error("pause did not release the bank");
   a_sel_hold: assert property (
      lock_o && $past(lock_o) |-> $stable(array_op_o)
      && $stable(array_bank_o))
      else $error("operation changed while running");
   a_read_lock: assert property (
      lock_o && rd_i && addr_i != `FWS_OFS_STAT_LO |=> rdata_o == 16'h0000)
      else $error("locked register read returned data");

   c_erase_run: cover property (lock_o && is_erase);
   c_pause: cover property (lock_o && pause_wr);
   c_nested: cover property (erase_held_reg && lock_o && !is_erase);
endmodule // fws_checker

bind fws_ctrl fws_checker #(.ADDR_W(ADDR_W)) fws_checker_i (
   .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .array_fail_i(array_fail_i), .bank_busy_o(bank_busy_o),
   .lock_o(lock_o), .array_run_o(array_run_o), .array_op_o(array_op_o),
   .array_bank_o(array_bank_o));
`default_nettype wire

/* File: fws_array_model.sv */
// Behavioural flash array that reports a cell failure on request
`timescale 1ns/100ps
`default_nettype none
module fws_array_model (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   input  wire logic run_i,
   input  wire logic fail_req_i,
   output logic      fail_o
);
   // Failure is registered, so it shows one cycle after a cycle in which an operation runs with a request
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fail_o <= 1'b0;
      end else begin
         fail_o <= run_i && fail_req_i;
      end
   end
endmodule // fws_array_model
`default_nettype wire

/* File: fws_ctrl_test.sv */
// Self-checking bench for the flash write sequencer control block
`timescale 1ns/100ps
`default_nettype none
`include "fws_cfg.svh"
module fws_ctrl_test;
   logic        clk_i;
   logic        nrst_i;
   logic [23:0] addr_i;
   logic [15:0] wdata_i;
   logic        wr_i;
   logic        rd_i;
   logic [15:0] rdata_o;
   logic        fail;
   logic        fail_req;
   logic [1:0]  bank_busy_o;
   logic        lock_o;
   logic        array_run_o;
   logic [2:0]  array_op_o;
   logic        array_bank_o;
   logic [15:0] d;
   int          mismatches;
   int          tests_run;

   fws_ctrl #(.PROG_TICKS(2), .ERASE_TICKS(3)) fws_ctrl_i (
      .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .array_fail_i(fail),
      .bank_busy_o(bank_busy_o), .lock_o(lock_o),
      .array_run_o(array_run_o), .array_op_o(array_op_o),
      .array_bank_o(array_bank_o));
   fws_array_model fws_array_model_i (
      .clk_i(clk_i), .nrst_i(nrst_i), .run_i(array_run_o),
      .fail_req_i(fail_req), .fail_o(fail));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic complete_run;
      if (mismatches == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] e);
      tests_run++;
      if (got !== e) begin
         mismatches++;
         $display("ERROR %0t: got %h expected %h", $time, got, e);
      end
   endtask

   task automatic wr(input logic [23:0] a, input logic [15:0] v);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask

   task automatic rd_chk(input logic [23:0] a, input logic [15:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1 chk(rdata_o, e);
   endtask

   // Packs lock, run, busy, select and bank into one byte
   task automatic flags(input logic [7:0] e);
      chk({8'h00, lock_o, array_run_o, bank_busy_o, array_op_o,
           array_bank_o}, {8'h00, e});
   endtask

   task automatic wait_idle;
      int n;
      n = 0;
      while (lock_o !== 1'b0) begin
         @(posedge clk_i);
         #1 n++;
         if (n > 2000) begin
            mismatches++;
            $display("ERROR %0t: operation never ended", $time);
            complete_run();
         end
      end
   endtask

   initial begin
      nrst_i = 1'b0;
      addr_i = 24'h000000;
      wdata_i = 16'h0000;
      wr_i = 1'b0;
      rd_i = 1'b0;
      fail_req = 1'b0;
      mismatches = 0;
      tests_run = 0;
      d = 16'($urandom(32'hF007));
      repeat (8) @(posedge clk_i);
      nrst_i <= 1'b1;
      rd_chk(`FWS_OFS_CTL_HI, `FWS_RST_CTL);
      rd_chk(`FWS_OFS_SEC_LO, `FWS_RST_SEC);
      rd_chk(`FWS_OFS_SEC_HI, `FWS_RST_SEC);
      rd_chk(`FWS_OFS_DATA_BASE, `FWS_RST_DATA);
      rd_chk(24'h0E0020, 16'h0000);
      d = 16'($urandom);
      wr(`FWS_OFS_SEC_LO, d);
      rd_chk(`FWS_OFS_SEC_LO, d & 16'h03FF);
      wr(`FWS_OFS_SEC_HI, d & 16'h3FFF);
      rd_chk(`FWS_OFS_SEC_HI, d & 16'h0003);
      wr(`FWS_OFS_DATA_BASE, d);
      rd_chk(`FWS_OFS_DATA_BASE, d);
      // Word program, bank 0; zero write and locked accesses meanwhile
      wr(`FWS_OFS_ADDR_HI, 16'h0000);
      wr(`FWS_OFS_CTL_HI, 16'hA000);
      #1 flags(8'hD8);
      wr(`FWS_OFS_CTL_HI, 16'h0000);
      #1 flags(8'hD8);
      wr(`FWS_OFS_DATA_BASE, ~d);
      rd_chk(`FWS_OFS_SEC_LO, 16'h0000);
      rd_chk(`FWS_OFS_STAT_LO, 16'h0012);
      wait_idle();
      flags(8'h00);
      rd_chk(`FWS_OFS_DATA_BASE, d);
      rd_chk(`FWS_OFS_SEC_LO, 16'h0000);
      // Erase, pause, nested program on bank 1, then erase resume
      wr(`FWS_OFS_SEC_LO, 16'h0201);
      wr(`FWS_OFS_CTL_HI, 16'h8800);
      #1 flags(8'hD2);
      wr(`FWS_OFS_CTL_HI, 16'h4800);
      #1 flags(8'h00);
      rd_chk(`FWS_OFS_SEC_HI, 16'h4000);
      rd_chk(`FWS_OFS_SEC_LO, 16'h0201);
      wr(`FWS_OFS_ADDR_HI, 16'h0004);
      wr(`FWS_OFS_CTL_HI, 16'hA000);
      #1 flags(8'hE9);
      wr(`FWS_OFS_CTL_HI, 16'h6000);
      #1 flags(8'hE9);
      wait_idle();
      wr(`FWS_OFS_CTL_HI, 16'h8800);
      #1 flags(8'hD2);
      wait_idle();
      rd_chk(`FWS_OFS_SEC_LO, 16'h0000);
      rd_chk(`FWS_OFS_SEC_HI, 16'h0000);
      // Program pause, then a wrong resume and a start under error
      wr(`FWS_OFS_SEC_LO, 16'h0001);
      wr(`FWS_OFS_ADDR_HI, 16'h0000);
      wr(`FWS_OFS_CTL_HI, 16'hA000);
      wr(`FWS_OFS_CTL_HI, 16'h6000);
      #1 flags(8'h00);
      wr(`FWS_OFS_DATA_BASE, ~d);
      wr(`FWS_OFS_CTL_HI, 16'h8800);
      #1 flags(8'h00);
      rd_chk(`FWS_OFS_ERR, 16'h0081);
      rd_chk(`FWS_OFS_DATA_BASE, d);
      wr(`FWS_OFS_CTL_HI, 16'hA000);
      #1 flags(8'h00);
      rd_chk(`FWS_OFS_ERR, 16'h0081);
      wr(`FWS_OFS_ERR, 16'h0000);
      rd_chk(`FWS_OFS_ERR, 16'h0000);
      // Start with the pause bit set is a sequence error; select kept
      wr(`FWS_OFS_CTL_HI, 16'hC800);
      rd_chk(`FWS_OFS_ERR, 16'h0041);
      rd_chk(`FWS_OFS_CTL_HI, 16'h6000);
      wr(`FWS_OFS_ERR, 16'h0000);
      // Erase on bank 1 with an array failure
      wr(`FWS_OFS_SEC_LO, 16'h0000);
      wr(`FWS_OFS_SEC_HI, 16'h0002);
      fail_req <= 1'b1;
      wr(`FWS_OFS_CTL_HI, 16'h8800);
      #1 flags(8'hE3);
      wait_idle();
      fail_req <= 1'b0;
      rd_chk(`FWS_OFS_ERR, 16'h0003);
      rd_chk(`FWS_OFS_SEC_HI, 16'h8002);
      complete_run();
   end
endmodule // fws_ctrl_test
`default_nettype wire
